// ---- hw/dapm_pkg.sv ----
package dapm_pkg;

  localparam int         SAMPLE_W             = 8;
  localparam int         WORD_W               = 4 * SAMPLE_W;
  localparam int         PIN_W                = 11;
  localparam int         CNT_W                = 24;
  localparam int         SER_BITS             = 16;
  localparam int         SER_CNT_W            = 4;

  // three-level strap codes from the pad comparators; 2'h2 and 2'h3 mean floating or mid
  localparam logic [1:0] LVL_LOW              = 2'h0;
  localparam logic [1:0] LVL_HIGH             = 2'h1;

  localparam logic [7:0] OFFSET_FLIP          = 8'h80;

  localparam int         TRIM_LOW_MIN_CYCLES  = 80;
  localparam int         TRIM_HIGH_MIN_CYCLES = 80;
  localparam int         CAL_RUN_CYCLES       = 1400;
  localparam int         CAL_DLY_SHORT_CYCLES = 1024;
  localparam int         CAL_DLY_LONG_CYCLES  = 65536;

  // positions in the synchronised strap vector
  localparam int         PIN_RANGE            = 0;
  localparam int         PIN_SWING            = 2;
  localparam int         PIN_EDGE             = 3;
  localparam int         PIN_DLY              = 5;
  localparam int         PIN_PD               = 7;
  localparam int         PIN_PDQ              = 8;
  localparam int         PIN_TRIG             = 9;
  localparam int         PIN_REALIGN          = 10;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_RUN  = 3'b100
  } dapm_cal_e;

  function automatic logic dapm_is_mid(input logic [1:0] code);
    return code[1];
  endfunction : dapm_is_mid

  function automatic logic dapm_is_high(input logic [1:0] code);
    return code == LVL_HIGH;
  endfunction : dapm_is_high

endpackage : dapm_pkg

// ---- hw/dapm_sync.sv ----
`timescale 1ns/1ps
module dapm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,    // destination clock
  input  wire logic         rst_n_i,  // async reset, active low
  input  wire logic [W-1:0] async_i,  // level from another domain
  output logic      [W-1:0] stable_o  // accepted level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit is taken only once two later stages agree, filtering single-edge glitches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_q <= '0;
    end else begin
      stable_q <= (s2_q & ~(s2_q ^ s3_q)) | (stable_q & (s2_q ^ s3_q));
    end
  end

  assign stable_o = stable_q;
endmodule : dapm_sync

// ---- hw/dapm_buf.sv ----
`timescale 1ns/1ps
module dapm_buf #(
  parameter int W = 32
) (
  input  wire logic         clk_i,       // clock
  input  wire logic         rst_n_i,     // async reset, active low
  input  wire logic         in_valid_i,  // word offered
  output logic              in_ready_o,  // room for a word
  input  wire logic [W-1:0] in_data_i,   // word in
  output logic              out_valid_o, // word available
  input  wire logic         out_ready_i, // word taken
  output logic      [W-1:0] out_data_o   // oldest word
);
  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready_o  = cnt_q != 2'h2;
  assign out_valid_o = cnt_q != 2'h0;
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : dapm_buf

// ---- hw/dapm_top.sv ----
`timescale 1ns/1ps
module dapm_top
  import dapm_pkg::*;
#(
  parameter int CAL_DLY_LONG = dapm_pkg::CAL_DLY_LONG_CYCLES
) (
  input  wire logic                          clk_i,                         // sample clock
  input  wire logic                          rst_n_i,                       // async reset
  input  wire logic                          serial_shift_clock_i,          // link clock
  input  wire logic                          serial_data_in_i,              // serial bit
  input  wire logic                          serial_select_n_i,             // serial select
  input  wire logic [1:0]                    range_or_ext_enable_i,         // strap code
  input  wire logic                          output_swing_select_i,         // amplitude pin
  input  wire logic [1:0]                    data_edge_select_i,            // strap code
  input  wire logic [1:0]                    selftune_start_delay_i,        // strap code
  input  wire logic                          full_power_down_i,             // power down all
  input  wire logic                          second_channel_power_down_i,   // power down Q
  input  wire logic                          selftune_trigger_i,            // self-tune pin
  input  wire logic                          output_clock_realign_i,        // realign pulse
  input  wire logic [dapm_pkg::SAMPLE_W-1:0] sample_i_i,                    // I core code
  input  wire logic [dapm_pkg::SAMPLE_W-1:0] sample_q_i,                    // Q core code
  output logic      [dapm_pkg::SAMPLE_W-1:0] data_i_a_o,                    // I even bus
  output logic      [dapm_pkg::SAMPLE_W-1:0] data_i_b_o,                    // I odd bus
  output logic      [dapm_pkg::SAMPLE_W-1:0] data_q_a_o,                    // Q even bus
  output logic      [dapm_pkg::SAMPLE_W-1:0] data_q_b_o,                    // Q odd bus
  output logic                               data_valid_o,                  // buses hold word
  input  wire logic                          data_ready_i,                  // capture ready
  output logic                               output_word_clock_o,           // word clock
  output logic                               overrun_o,                     // stalled cycle's sample lost
  output logic                               ext_mode_o,                    // extended mode
  output logic                               range_high_o,                  // higher range
  output logic                               swing_reduced_o,               // low amplitude
  output logic                               ddr_mode_o,                    // both edges
  output logic                               interleave_o,                  // dual-edge mode
  output logic                               power_down_o,                  // all powered down
  output logic                               q_power_down_o,                // Q powered down
  output logic                               selftune_running_o,            // self-tune busy
  output logic      [dapm_pkg::SER_BITS-1:0] serial_word_o,                 // last serial word
  output logic                               serial_word_valid_o            // new serial word
);
  import dapm_pkg::*;

  logic [PIN_W-1:0]     pins_raw;
  logic [PIN_W-1:0]     pins_s;
  logic [1:0]           range_code;
  logic [1:0]           edge_code;
  logic [1:0]           dly_code;
  logic                 ext_mode;
  logic                 edge_rise;
  logic                 ddr_mode;
  logic                 interleave;
  logic                 pd_all;
  logic                 pd_q;
  logic                 trig_s;
  logic                 realign_s;
  logic                 realign_prev_q;
  logic                 realign_pulse;

  assign pins_raw = {output_clock_realign_i, selftune_trigger_i, second_channel_power_down_i,
                     full_power_down_i, selftune_start_delay_i, data_edge_select_i,
                     output_swing_select_i, range_or_ext_enable_i};

  dapm_sync #(.W(PIN_W)) u_pin_sync (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .async_i  (pins_raw),
    .stable_o (pins_s)
  );

  assign range_code = pins_s[PIN_RANGE+1:PIN_RANGE];
  assign edge_code  = pins_s[PIN_EDGE+1:PIN_EDGE];
  assign dly_code   = pins_s[PIN_DLY+1:PIN_DLY];
  assign pd_all     = pins_s[PIN_PD];
  assign pd_q       = pins_s[PIN_PDQ];
  assign trig_s     = pins_s[PIN_TRIG];
  assign realign_s  = pins_s[PIN_REALIGN];

  // decode follows the synchronised straps every cycle, so a pin change re-decodes
  assign ext_mode   = dapm_is_mid(range_code);
  // in extended mode the strap-owned settings fall back to fixed defaults
  assign ddr_mode   = !ext_mode && dapm_is_mid(edge_code);
  assign edge_rise  = ext_mode || dapm_is_high(edge_code);
  assign interleave = !ext_mode && dapm_is_mid(dly_code);

  assign ext_mode_o      = ext_mode;
  assign range_high_o    = ext_mode || dapm_is_high(range_code);
  assign swing_reduced_o = !ext_mode && !pins_s[PIN_SWING];
  assign ddr_mode_o      = ddr_mode;
  assign interleave_o    = interleave;
  assign power_down_o    = pd_all;
  assign q_power_down_o  = pd_all || pd_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      realign_prev_q <= 1'b0;
    end else begin
      realign_prev_q <= realign_s;
    end
  end
  assign realign_pulse = realign_s && !realign_prev_q;

  // ---------------- sampling ----------------
  logic [SAMPLE_W-1:0] smp_fall_i_q;
  logic [SAMPLE_W-1:0] smp_fall_q_q;
  logic [SAMPLE_W-1:0] smp_rise_i_q;
  logic [SAMPLE_W-1:0] chan_i;
  logic [SAMPLE_W-1:0] chan_q;

  always_ff @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_fall_i_q <= '0;
      smp_fall_q_q <= '0;
    end else begin
      smp_fall_i_q <= sample_i_i ^ OFFSET_FLIP;
      smp_fall_q_q <= sample_q_i ^ OFFSET_FLIP;
    end
  end

  // second I sample per period, only used when interleaving
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_rise_i_q <= '0;
    end else begin
      smp_rise_i_q <= sample_i_i ^ OFFSET_FLIP;
    end
  end

  assign chan_i = smp_fall_i_q;
  always_comb begin
    if (pd_q && !interleave) begin
      chan_q = '0;
    end else if (interleave) begin
      chan_q = smp_rise_i_q;
    end else begin
      chan_q = smp_fall_q_q;
    end
  end

  // ---------------- demultiplex ----------------
  logic                phase_q;
  logic [SAMPLE_W-1:0] first_i_q;
  logic [SAMPLE_W-1:0] first_q_q;
  logic                push_valid;
  logic                push_ready;
  logic [WORD_W-1:0]   push_data;
  logic                overrun_q;

  assign push_valid = !pd_all && phase_q;
  assign push_data  = {chan_q, first_q_q, chan_i, first_i_q};

  // a full buffer holds the pair phase; the samples of that cycle are lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 1'b0;
    end else if (pd_all || realign_pulse) begin
      phase_q <= 1'b0;
    end else if (!phase_q || push_ready) begin
      phase_q <= ~phase_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_i_q <= '0;
      first_q_q <= '0;
    end else if (!phase_q) begin
      first_i_q <= chan_i;
      first_q_q <= chan_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= push_valid && !push_ready;
    end
  end
  assign overrun_o = overrun_q;

  logic              buf_valid;
  logic              buf_ready;
  logic [WORD_W-1:0] buf_data;

  dapm_buf #(.W(WORD_W)) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  // ---------------- output word clock and launch ----------------
  logic              wclk_q;
  logic              launch;
  logic              out_valid_q;
  logic [WORD_W-1:0] out_word_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wclk_q <= 1'b0;
    end else if (pd_all || realign_pulse) begin
      wclk_q <= 1'b0;
    end else begin
      wclk_q <= ~wclk_q;
    end
  end
  assign output_word_clock_o = wclk_q;

  // launch marks the cycle in which the word clock makes the selected transition
  assign launch    = !pd_all && !realign_pulse &&
                     (ddr_mode || (edge_rise ? !wclk_q : wclk_q));
  assign buf_ready = launch && (!out_valid_q || data_ready_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_word_q <= '0;
    end else if (buf_ready && buf_valid) begin
      out_word_q <= buf_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_q <= 1'b0;
    end else if (buf_ready) begin
      out_valid_q <= buf_valid;
    end else if (data_ready_i) begin
      out_valid_q <= 1'b0;
    end
  end

  assign data_valid_o = out_valid_q;
  assign data_i_a_o   = out_word_q[SAMPLE_W-1:0];
  assign data_i_b_o   = out_word_q[2*SAMPLE_W-1:SAMPLE_W];
  assign data_q_a_o   = out_word_q[3*SAMPLE_W-1:2*SAMPLE_W];
  assign data_q_b_o   = out_word_q[4*SAMPLE_W-1:3*SAMPLE_W];

  // ---------------- self-tune ----------------
  dapm_cal_e         cal_q;
  logic [CNT_W-1:0]  cal_cnt_q;
  logic [CNT_W-1:0]  dly_limit;
  logic [7:0]        low_cnt_q;
  logic [7:0]        high_cnt_q;
  logic              armed_q;
  logic              cal_start;

  // low phase must be fully seen before the high phase counts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_q  <= '0;
      high_cnt_q <= '0;
      armed_q    <= 1'b0;
    end else if (!trig_s) begin
      high_cnt_q <= '0;
      if (low_cnt_q == 8'(TRIM_LOW_MIN_CYCLES - 1)) begin
        armed_q <= 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q + 8'h01;
      end
    end else begin
      low_cnt_q <= '0;
      if (cal_start) begin
        armed_q <= 1'b0;
      end else if (armed_q) begin
        high_cnt_q <= high_cnt_q + 8'h01;
      end
    end
  end
  assign cal_start = armed_q && trig_s &&
                     high_cnt_q == 8'(TRIM_HIGH_MIN_CYCLES - 1);

  always_comb begin
    if (!ext_mode && dapm_is_high(dly_code)) begin
      dly_limit = CNT_W'(CAL_DLY_LONG - 1);
    end else begin
      dly_limit = CNT_W'(CAL_DLY_SHORT_CYCLES - 1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_q     <= ST_WAIT;
      cal_cnt_q <= '0;
    end else if (pd_all) begin
      cal_q     <= ST_IDLE;
      cal_cnt_q <= '0;
    end else begin
      unique case (cal_q)
        ST_WAIT: begin
          cal_cnt_q <= cal_cnt_q + CNT_W'(1);
          if (cal_cnt_q >= dly_limit) begin
            cal_q     <= ST_RUN;
            cal_cnt_q <= '0;
          end
        end
        ST_IDLE: begin
          if (cal_start) begin
            cal_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          cal_cnt_q <= cal_cnt_q + CNT_W'(1);
          if (cal_cnt_q == CNT_W'(CAL_RUN_CYCLES - 1)) begin
            cal_q     <= ST_IDLE;
            cal_cnt_q <= '0;
          end
        end
        default: begin
          cal_q     <= ST_IDLE;
          cal_cnt_q <= '0;
        end
      endcase
    end
  end
  assign selftune_running_o = cal_q == ST_RUN;

  // ---------------- serial link, shift clock domain ----------------
  logic                 link_rst_n;
  logic [SER_BITS-1:0]  shift_q;
  logic [SER_CNT_W-1:0] bit_cnt_q;
  logic [SER_BITS-1:0]  frame_q;
  logic                 frame_tgl_q;

  // a deasserted select ends the frame even though the shift clock is stopped
  assign link_rst_n = rst_n_i && !serial_select_n_i;

  always_ff @(posedge serial_shift_clock_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
    end else begin
      shift_q   <= {shift_q[SER_BITS-2:0], serial_data_in_i};
      bit_cnt_q <= bit_cnt_q + SER_CNT_W'(1);
    end
  end

  always_ff @(posedge serial_shift_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_q     <= '0;
      frame_tgl_q <= 1'b0;
    end else if (!serial_select_n_i && bit_cnt_q == SER_CNT_W'(SER_BITS - 1)) begin
      frame_q     <= {shift_q[SER_BITS-2:0], serial_data_in_i};
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // ---------------- serial word into the sample clock domain ----------------
  logic                tgl_s;
  logic                tgl_seen_q;
  logic [SER_BITS-1:0] ser_word_q;
  logic                ser_valid_q;

  dapm_sync #(.W(1)) u_tgl_sync (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .async_i  (frame_tgl_q),
    .stable_o (tgl_s)
  );

  // frame_q stays put for a whole further frame after its toggle, so it is stable here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_seen_q  <= 1'b0;
      ser_word_q  <= '0;
      ser_valid_q <= 1'b0;
    end else begin
      tgl_seen_q  <= tgl_s;
      ser_valid_q <= 1'b0;
      if (tgl_s != tgl_seen_q && ext_mode) begin
        ser_word_q  <= frame_q;
        ser_valid_q <= 1'b1;
      end
    end
  end

  assign serial_word_o       = ser_word_q;
  assign serial_word_valid_o = ser_valid_q;
endmodule : dapm_top

// ---- test/dapm_host.sv ----
`timescale 1ns/1ps
module dapm_host (
  input  wire logic clk_i,       // sample clock
  input  wire logic rst_n_i,     // async reset
  input  wire logic slow_i,      // stall capture
  output logic      data_ready_o // capture ready
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end
  // one word in eight when slow, so the two-entry buffer fills and overruns
  assign data_ready_o = !slow_i || (cnt_q == 3'h0);
endmodule : dapm_host

// ---- test/dapm_chk.sv ----
`timescale 1ns/1ps
module dapm_chk
  import dapm_pkg::*;
(
  input wire logic                          clk_i,               // clock
  input wire logic                          rst_n_i,             // reset
  input wire logic [1:0]                    range_or_ext_enable_i, // strap
  input wire logic [1:0]                    data_edge_select_i,  // strap
  input wire logic                          data_ready_i,        // ready
  input wire logic                          output_clock_realign_i, // realign pin
  input wire logic [dapm_pkg::SAMPLE_W-1:0] data_i_a_o,          // I bus a
  input wire logic [dapm_pkg::SAMPLE_W-1:0] data_q_b_o,          // Q bus b
  input wire logic                          data_valid_o,        // valid
  input wire logic                          output_word_clock_o, // word clock
  input wire logic                          overrun_o,           // lost sample
  input wire logic                          ext_mode_o,          // extended
  input wire logic                          range_high_o,        // range
  input wire logic                          swing_reduced_o,     // amplitude
  input wire logic                          ddr_mode_o,          // ddr
  input wire logic                          interleave_o,        // interleave
  input wire logic                          power_down_o,        // power down
  input wire logic                          selftune_running_o,  // self-tune
  input wire logic                          serial_word_valid_o  // serial word
);
  logic [3:0]  up_q;
  logic [10:0] run_q;
  // decode is blind to straps until the synchronisers have filled after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_q <= 4'h0;
    else if (up_q != 4'hF) up_q <= up_q + 4'h1;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) run_q <= 11'h0;
    else run_q <= selftune_running_o ? run_q + 11'h1 : 11'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ext;
    ext_mode_o |-> range_high_o && !swing_reduced_o && !ddr_mode_o && !interleave_o;
  endproperty
  property p_rng;
    up_q > 4'h8 && $past(range_or_ext_enable_i, 3) == $past(range_or_ext_enable_i, 4)
      && $past(range_or_ext_enable_i, 4) == $past(range_or_ext_enable_i, 5)
      |-> ext_mode_o == $past(range_or_ext_enable_i[1], 3)
      && (ext_mode_o || range_high_o == $past(range_or_ext_enable_i[0], 3));
  endproperty
  property p_ddr;
    up_q > 4'h8 && $past(data_edge_select_i, 3) == $past(data_edge_select_i, 4)
      && $past(data_edge_select_i, 4) == $past(data_edge_select_i, 5)
      |-> ddr_mode_o == (!ext_mode_o && $past(data_edge_select_i[1], 3));
  endproperty
  property p_pdclk;
    power_down_o ##1 power_down_o |-> !output_word_clock_o;
  endproperty
  property p_pdrun;
    power_down_o ##1 power_down_o |-> !selftune_running_o;
  endproperty
  property p_hold;
    data_valid_o && !data_ready_i |=> data_valid_o && $stable(data_i_a_o) && $stable(data_q_b_o);
  endproperty
  property p_run;
    $fell(selftune_running_o) && !$past(power_down_o) |-> run_q == 11'h578;
  endproperty
  // a pulse held three samples reaches the word clock six edges after it rose
  property p_rlg;
    $past(output_clock_realign_i, 3) && $past(output_clock_realign_i, 4)
      && $past(output_clock_realign_i, 5) && !$past(output_clock_realign_i, 6)
      && !power_down_o |-> !output_word_clock_o ##1 output_word_clock_o;
  endproperty
  property p_ser;
    serial_word_valid_o |-> ext_mode_o;
  endproperty
  a_ext: assert property (p_ext) else $error("ext defaults wrong");
  a_rng: assert property (p_rng) else $error("range decode wrong");
  a_ddr: assert property (p_ddr) else $error("ddr decode wrong");
  a_pdclk: assert property (p_pdclk) else $error("word clock in power down");
  a_pdrun: assert property (p_pdrun) else $error("self-tune in power down");
  a_hold: assert property (p_hold) else $error("stalled word changed");
  a_run: assert property (p_run) else $error("self-tune length wrong");
  a_ser: assert property (p_ser) else $error("serial word outside ext");
  a_rlg: assert property (p_rlg) else $error("word clock not realigned");
  c_run: cover property ($rose(selftune_running_o));
  c_ovr: cover property (overrun_o);
  c_ser: cover property (serial_word_valid_o);
endmodule : dapm_chk
bind dapm_top dapm_chk dapm_chk_i (.*);

// ---- test/dapm_tb_top.sv ----
`timescale 1ns/1ps
module dapm_tb_top;
  import dapm_pkg::*;
  localparam logic [1:0] RG [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  localparam logic [1:0] ED [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  localparam logic [3:0] EX [4] = '{4'h1, 4'h4, 4'hC, 4'h6};
  logic        clk_i = 1'b0, rst_n_i = 1'b0, sclk = 1'b1, sel_n = 1'b1, pd = 1'b0;
  logic        second_channel_power_down = 1'b0, trig = 1'b0, rlg = 1'b0, slow = 1'b0, hq = 1'b0, qz = 1'b0;
  logic        ovr = 1'b0, rdy;
  logic [3:0]  pdd = 4'h0;
  logic [1:0]  dly = 2'h0;
  logic [1:0]  rg = 2'h1, ed = 2'h1;
  logic [7:0]  r = 8'h1A, si = 8'h00, sqs = 8'h00;
  logic [7:0]  data_i_a_o, data_i_b_o, data_q_a_o, data_q_b_o;
  logic [15:0] serial_word_o;
  logic        data_valid_o, output_word_clock_o, overrun_o, ext_mode_o, range_high_o;
  logic        swing_reduced_o, ddr_mode_o, interleave_o, power_down_o, q_power_down_o;
  logic        selftune_running_o, serial_word_valid_o;
  logic [15:0] dq [$];
  logic [15:0] sq [$];
  int          fails = 0;
  int          samples_checked = 0;
  int          k;
  always #5 clk_i = ~clk_i;
  dapm_top #(.CAL_DLY_LONG(2000)) dapm_top_i (
    .serial_shift_clock_i(sclk), .output_swing_select_i(sclk), .serial_data_in_i(ed[0]),
    .serial_select_n_i(sel_n), .range_or_ext_enable_i(rg), .data_edge_select_i(ed),
    .selftune_start_delay_i(dly), .full_power_down_i(pd), .second_channel_power_down_i(second_channel_power_down),
    .selftune_trigger_i(trig), .output_clock_realign_i(rlg), .sample_i_i(si),
    .sample_q_i(sqs), .data_ready_i(rdy), .*);
  dapm_host dapm_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .data_ready_o(rdy));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  task automatic wrun(input logic v, input int n);
    for (int j = 0; j < n && selftune_running_o !== v; j++) tk(1);
    chk(selftune_running_o, v, "selftune running");
  endtask : wrun
  // the link clock runs only inside a frame and idles high
  task automatic frame(input logic [15:0] w, input logic note);
    if (note) sq.push_back(w);
    sel_n = 1'b0;
    #23;
    for (int b = 15; b >= 0; b--) begin
      sclk = 1'b0;
      ed = {1'b0, w[b]};
      #32;
      sclk = 1'b1;
      #32;
    end
    #23;
    sel_n = 1'b1;
    ed = 2'h1;
  endtask : frame
  always @(posedge clk_i) begin
    // power down reaches the pair logic only after its pin synchroniser
    pdd = {pdd[2:0], pd};
    #1;
    r = lfsr(r);
    si = r;
    sqs = hq ? 8'h80 : {r[3:0], r[7:4]};
    if (rst_n_i && !pdd[3]) dq.push_back({si ^ 8'h80, qz ? 8'h00 : sqs ^ 8'h80});
  end
  always @(posedge clk_i) begin
    if (rst_n_i === 1'b1 && data_valid_o === 1'b1 && rdy === 1'b1) begin
      // overruns drop the stalled cycle's sample, so skip stale notes until bus a matches
      k = 0;
      while (dq.size() > 2 && dq[0] !== {data_i_a_o, data_q_a_o} && k < 16) begin
        void'(dq.pop_front());
        k++;
      end
      chk({data_i_a_o, data_q_a_o, data_i_b_o, data_q_b_o}, {dq[0], dq[1]}, "word");
      void'(dq.pop_front());
      void'(dq.pop_front());
    end
    if (overrun_o === 1'b1) begin
      // the stalled cycle's sample is lost and the pair phase held: drop its note
      ovr = 1'b1;
      if (dq.size() >= 2) dq.delete(dq.size() - 2);
    end
    if (serial_word_valid_o === 1'b1) begin
      if (sq.size() == 0) chk(1'b1, 1'b0, "stray serial word");
      else chk(serial_word_o, sq.pop_front(), "serial word");
    end
  end
  initial begin
    repeat (12000) @(posedge clk_i);
    fails++;
    test_done();
  end
  initial begin
    tk(4);
    rst_n_i = 1'b1;
    tk(6);
    for (int i = 0; i < 4; i++) begin
      rg = RG[i];
      ed = ED[i];
      sclk = i[0];
      tk(8);
      chk({ext_mode_o, range_high_o, ddr_mode_o, swing_reduced_o}, EX[i], "mode");
    end
    rg = 2'h1;
    ed = 2'h1;
    sclk = 1'b1;
    slow = 1'b1;
    tk(200);
    slow = 1'b0;
    tk(40);
    chk(ovr, 1'b1, "overrun seen");
    hq = 1'b1;
    tk(10);
    second_channel_power_down = 1'b1;
    tk(10);
    chk({q_power_down_o, power_down_o}, 2'h2, "q power down");
    hq = 1'b0;
    qz = 1'b1;
    tk(40);
    hq = 1'b1;
    second_channel_power_down = 1'b0;
    tk(10);
    hq = 1'b0;
    qz = 1'b0;
    wrun(1'b1, 2000);
    wrun(1'b0, 1500);
    trig = 1'b1;
    tk(76);
    chk(selftune_running_o, 1'b0, "early self-tune");
    wrun(1'b1, 20);
    tk(100);
    pd = 1'b1;
    dly = 2'h2;
    tk(8);
    chk({power_down_o, selftune_running_o, output_word_clock_o, interleave_o}, 4'h9, "pd");
    dly = 2'h0;
    tk(8);
    pd = 1'b0;
    trig = 1'b0;
    rlg = 1'b1;
    tk(4);
    rlg = 1'b0;
    rg = 2'h2;
    tk(8);
    frame(16'hA5C3, 1'b1);
    tk(20);
    rg = 2'h1;
    tk(8);
    frame(16'h5A3C, 1'b0);
    tk(20);
    chk(sq.size(), 0, "serial pending");
    test_done();
  end
endmodule : dapm_tb_top
